// *** asp_regs.vh ***
`ifndef ASP_REGS_VH
`define ASP_REGS_VH
// setup byte layout (command byte with bits 7:6 = 01)
`define ASP_CMD_BITS 4'h8
`define ASP_SETUP_TAG 2'h1
`define ASP_SETUP_TAG_HI 7
`define ASP_SETUP_TAG_LO 6
`define ASP_CLOCK_MODE_SELECT_HI 5
`define ASP_CLOCK_MODE_SELECT_LO 4
`define ASP_REFSEL_HI 3
`define ASP_REFSEL_LO 2
`define ASP_CLOCK_MODE_SELECT_RESET 2'h2
`define ASP_REFSEL_RESET 2'h0
`define ASP_CLOCK_MODE_SELECT_EXT 2'h3
`define ASP_CLOCK_MODE_SELECT_CNV_HI 2'h1
`define ASP_REFSEL_EXT_DIFF 2'h3
`define ASP_RESULT_BITS 5'h10
`endif

// *** asp_sync.v ***
`timescale 1ns/1ps
module asp_sync
#(
    parameter RST_LVL = 1'b1 // level the pin rests at
)
(
    input wire mclk, // system clock
    input wire rstn, // async reset, active low
    input wire async_in, // pin level from outside
    output reg level_q, // debounced level
    output reg rise_q, // one-cycle pulse on rise
    output reg fall_q // one-cycle pulse on fall
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    // preset to the rest level so that no false edge follows reset
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= RST_LVL;
            s2_q <= RST_LVL;
            s3_q <= RST_LVL;
            level_q <= RST_LVL;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end
        else
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rise_q <= 1'b0;
            fall_q <= 1'b0;
            // a change counts only once stages two and three agree
            if (s2_q == s3_q && s2_q != level_q)
            begin
                level_q <= s2_q;
                rise_q <= s2_q;
                fall_q <= ~s2_q;
            end
        end
    end
endmodule // asp_sync

// *** asp_serial_pins.v ***
`timescale 1ns/1ps
`include "asp_regs.vh"
module asp_serial_pins
(
    input wire mclk, // 25 MHz system clock
    input wire rstn, // async reset, active low
    input wire sclk, // serial clock from host
    input wire cs_n, // chip select, active low
    input wire din, // serial data in
    input wire cnv_pin, // shared pin: convert_start_n or analog_input_fifteen
    input wire conv_done, // core pulse: result ready
    input wire [15:0] result, // core result word to shift out
    output reg dout_o, // serial data out
    output reg dout_oe, // serial data out enable
    output reg eoc_n_q, // end of conversion, active low
    output reg cmd_valid_q, // pulse: a whole byte arrived
    output reg [7:0] cmd_byte_q, // last received byte
    output reg first_byte_q, // received byte was the command byte
    output reg convert_start_q, // pulse: convert_start_n fell, pin in start role
    output reg cnv_is_start_q, // pin acts as convert_start_n
    output reg ref_minus_q, // other pin acts as reference minus
    output reg [1:0] clock_mode_select_q // clock mode field of setup
);
    wire sclk_rise;
    wire sclk_fall;
    wire cs_lvl;
    wire cs_fall;
    wire din_lvl;
    wire cnv_fall;
    wire start_edge;
    reg [2:0] bit_cnt_q;
    reg [7:0] shift_in_q;
    reg first_q;
    reg [15:0] shift_out_q;
    reg [15:0] result_q;
    // next values of the setup decode and of the end-of-conversion flag
    reg [7:0] rx_byte_d;
    reg setup_hit_d;
    reg [1:0] mode_d;
    reg start_role_d;
    reg ref_minus_d;
    reg eoc_n_d;

    // reset levels follow the idle pins: sclk idles low, select and start idle high
    asp_sync
    #(
        .RST_LVL(1'b0)
    )
    u_sclk
    (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(sclk),
        .level_q(),
        .rise_q(sclk_rise),
        .fall_q(sclk_fall)
    );

    asp_sync
    #(
        .RST_LVL(1'b1)
    )
    u_cs
    (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(cs_n),
        .level_q(cs_lvl),
        .rise_q(),
        .fall_q(cs_fall)
    );

    asp_sync
    #(
        .RST_LVL(1'b0)
    )
    u_din
    (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(din),
        .level_q(din_lvl),
        .rise_q(),
        .fall_q()
    );

    asp_sync
    #(
        .RST_LVL(1'b1)
    )
    u_cnv
    (
        .mclk(mclk),
        .rstn(rstn),
        .async_in(cnv_pin),
        .level_q(),
        .rise_q(),
        .fall_q(cnv_fall)
    );

    assign start_edge = cnv_is_start_q && cnv_fall;

    // decode of the byte that completes on this serial clock rise
    always @*
    begin
        rx_byte_d = {shift_in_q[6:0], din_lvl};
        mode_d = rx_byte_d[`ASP_CLOCK_MODE_SELECT_HI:`ASP_CLOCK_MODE_SELECT_LO];
        setup_hit_d = first_q && (rx_byte_d[`ASP_SETUP_TAG_HI:`ASP_SETUP_TAG_LO] == `ASP_SETUP_TAG);
        // only the two pin-timed modes hand the shared pin to convert start
        start_role_d = (mode_d != `ASP_CLOCK_MODE_SELECT_RESET) && (mode_d != `ASP_CLOCK_MODE_SELECT_EXT);
        ref_minus_d = (rx_byte_d[`ASP_REFSEL_HI:`ASP_REFSEL_LO] == `ASP_REFSEL_EXT_DIFF);
    end

    // select or start fall beats a result arriving in the same cycle
    always @*
    begin
        eoc_n_d = eoc_n_q;
        if (clock_mode_select_q == `ASP_CLOCK_MODE_SELECT_EXT)
            eoc_n_d = 1'b1;
        else if (cs_fall || start_edge)
            eoc_n_d = 1'b1;
        else if (conv_done)
            eoc_n_d = 1'b0;
    end

    // receive path
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            bit_cnt_q <= 3'h0;
            shift_in_q <= 8'h00;
            first_q <= 1'b1;
            cmd_valid_q <= 1'b0;
            cmd_byte_q <= 8'h00;
            first_byte_q <= 1'b0;
            cnv_is_start_q <= 1'b0;
            ref_minus_q <= 1'b0;
            clock_mode_select_q <= `ASP_CLOCK_MODE_SELECT_RESET;
        end
        else
        begin
            cmd_valid_q <= 1'b0;
            if (cs_fall)
            begin
                bit_cnt_q <= 3'h0;
                first_q <= 1'b1;
            end
            else if (!cs_lvl && sclk_rise)
            begin
                shift_in_q <= {shift_in_q[6:0], din_lvl};
                bit_cnt_q <= bit_cnt_q + 3'h1;
                if (bit_cnt_q == 3'h7)
                begin
                    cmd_valid_q <= 1'b1;
                    cmd_byte_q <= rx_byte_d;
                    first_byte_q <= first_q;
                    first_q <= 1'b0;
                    // only the first byte of a frame can be the setup byte
                    if (setup_hit_d)
                    begin
                        clock_mode_select_q <= mode_d;
                        cnv_is_start_q <= start_role_d;
                        ref_minus_q <= ref_minus_d;
                    end
                end
            end
        end
    end

    // transmit path and pin drivers
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_out_q <= 16'h0000;
            result_q <= 16'h0000;
            dout_o <= 1'b0;
            dout_oe <= 1'b0;
        end
        else
        begin
            if (conv_done)
                result_q <= result;
            dout_oe <= ~cs_lvl;
            // the word is copied at select fall, so a new result cannot tear a frame
            if (cs_fall)
            begin
                shift_out_q <= result_q;
            end
            else if (!cs_lvl && sclk_fall)
            begin
                // zeros follow the last result bit
                dout_o <= shift_out_q[15];
                shift_out_q <= {shift_out_q[14:0], 1'b0};
            end
            if (cs_lvl)
                dout_o <= 1'b0;
        end
    end

    // end of conversion and convert start
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            eoc_n_q <= 1'b1;
            convert_start_q <= 1'b0;
        end
        else
        begin
            convert_start_q <= start_edge;
            eoc_n_q <= eoc_n_d;
        end
    end
endmodule // asp_serial_pins

// *** asp_properties.sv ***
`timescale 1ns/1ps
module asp_properties
(
    input wire mclk, // clock
    input wire rstn, // reset, low
    input wire sclk, // serial clock
    input wire cs_n, // select
    input wire cnv_pin, // shared start pin
    input wire conv_done, // result ready
    input wire dout_o, // data out
    input wire dout_oe, // out enable
    input wire eoc_n_q, // end of conversion
    input wire cmd_valid_q, // byte pulse
    input wire [7:0] cmd_byte_q, // byte
    input wire first_byte_q, // first byte
    input wire convert_start_q, // start pulse
    input wire cnv_is_start_q, // start role
    input wire ref_minus_q, // ref minus role
    input wire [1:0] clock_mode_select_q // mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // pins pass a synchroniser, so every bound allows a few cycles
    a_oe_on: assert property (!cs_n [*8] |-> dout_oe) else $error("oe low");
    a_oe_off: assert property (cs_n [*8] |-> !dout_oe) else $error("oe high");
    a_dout_hold: assert property (($changed(dout_o) && !cs_n) |-> (!$past(sclk, 4) && !$past(sclk, 5)))
        else $error("dout moved");
    a_idle_quiet: assert property (cs_n [*8] |-> !cmd_valid_q) else $error("byte idle");
    a_eoc_sel: assert property ($fell(cs_n) |-> ##[1:8] eoc_n_q) else $error("eoc low");
    a_eoc_done: assert property (cs_n [*8] ##0 (conv_done && clock_mode_select_q != 2'h3) |=> !eoc_n_q)
        else $error("eoc high");
    a_eoc_mode: assert property ((clock_mode_select_q == 2'h3) [*2] |-> eoc_n_q) else $error("eoc m3");
    a_start_role: assert property (convert_start_q |-> cnv_is_start_q) else $error("start");
    a_start_follow: assert property (($fell(cnv_pin) && cnv_is_start_q) |-> ##[3:8] convert_start_q)
        else $error("no start");
    a_setup_dec: assert property (cmd_valid_q && first_byte_q && cmd_byte_q[7:6] == 2'h1 |-> ##[1:3]
        (ref_minus_q == (cmd_byte_q[3:2] == 2'h3) && cnv_is_start_q == !cmd_byte_q[5])) else $error("setup");
    c_byte: cover property (cmd_valid_q && first_byte_q);
    c_start: cover property (convert_start_q);
    c_eoc: cover property ($fell(eoc_n_q));
endmodule // asp_properties

// *** asp_host.sv ***
`timescale 1ns/1ps
module asp_host
(
    input wire mclk, // system clock
    input wire sdo, // data line
    output reg sclk, // serial clock
    output reg cs_n, // select
    output reg din // data in
);
    initial {sclk, cs_n, din} = 3'h2;
    task automatic sel(input logic v);
        cs_n <= v;
        din <= ~din; // released line must not keep its value
        repeat (8) @(posedge mclk);
    endtask
    task automatic shift(input int n, input logic [7:0] tx, output logic [7:0] rx);
        for (int i = n - 1; i >= 0; i--)
        begin
            din <= tx[i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            rx[i] = sdo; // late in high phase, away from the fall
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
    endtask
endmodule // asp_host

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0, rstn = 1'b0, cnv_pin = 1'b1, conv_done = 1'b0;
    logic [15:0] result = 16'h0000;
    logic [7:0] r0, r1, r2;
    wire sclk, cs_n, din, dout_o, dout_oe, eoc_n_q, cmd_valid_q, first_byte_q, convert_start_q;
    wire cnv_is_start_q, ref_minus_q;
    wire [7:0] cmd_byte_q;
    wire [1:0] clock_mode_select_q;
    int bad_count = 0, num_checks = 0, nbytes = 0, nstarts = 0;
    always #20 mclk = ~mclk;
    always @(posedge mclk) nbytes <= nbytes + cmd_valid_q;
    always @(posedge mclk) nstarts <= nstarts + convert_start_q;
    asp_host u_host(.mclk, .sdo(dout_oe ? dout_o : 1'bz), .sclk, .cs_n, .din);
    asp_serial_pins i_asp_serial_pins(.mclk, .rstn, .sclk, .cs_n, .din, .cnv_pin, .conv_done, .result, .dout_o,
        .dout_oe, .eoc_n_q, .cmd_valid_q, .cmd_byte_q, .first_byte_q, .convert_start_q, .cnv_is_start_q,
        .ref_minus_q, .clock_mode_select_q);
    task automatic chk(input string what, input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic t_read();
        result <= 16'hA5C3;
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("eoc low", eoc_n_q, 1'b0);
        u_host.sel(1'b0);
        chk("eoc high", eoc_n_q, 1'b1);
        chk("oe on", dout_oe, 1'b1);
        u_host.shift(8, 8'h00, r0);
        u_host.shift(8, 8'h81, r1);
        u_host.shift(8, 8'h7E, r2);
        chk("dout", {r0[6:0], r1, r2[7]}, 16'hA5C3);
        chk("byte", cmd_byte_q, 8'h7E);
        chk("bytes", nbytes, 3);
        chk("not first", first_byte_q, 1'b0);
        u_host.sel(1'b1);
        chk("oe off", dout_oe, 1'b0);
        $display("read done");
    endtask
    task automatic t_setup();
        int k;
        for (int m = 0; m < 4; m++)
        begin
            u_host.sel(1'b0);
            u_host.shift(8, {2'h1, m[1:0], m[0] ? 2'h3 : 2'h0, 2'h0}, r0);
            u_host.sel(1'b1);
            chk("mode", clock_mode_select_q, m[1:0]);
            chk("start role", cnv_is_start_q, !m[1]);
            chk("ref minus", ref_minus_q, m[0]);
            conv_done <= 1'b1;
            @(posedge mclk);
            conv_done <= 1'b0;
            repeat (4) @(posedge mclk);
            chk("eoc done", eoc_n_q, m == 3);
            k = nstarts;
            cnv_pin <= 1'b0;
            repeat (8) @(posedge mclk);
            cnv_pin <= 1'b1;
            repeat (8) @(posedge mclk);
            chk("eoc cnv", eoc_n_q, m != 2);
            chk("starts", nstarts - k, m < 2);
        end
        $display("setup done");
    endtask
    initial
    begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("eoc rst", eoc_n_q, 1'b1);
        chk("mode rst", clock_mode_select_q, 2'h2);
        u_host.shift(8, 8'hFF, r0);
        chk("idle bytes", nbytes, 0);
        chk("oe idle", dout_oe, 1'b0);
        $display("idle done");
        t_read();
        t_setup();
        u_host.sel(1'b0);
        u_host.shift(3, 8'h07, r0);
        u_host.sel(1'b1);
        u_host.sel(1'b0);
        u_host.shift(8, 8'h5A, r0);
        chk("byte", cmd_byte_q, 8'h5A);
        chk("first", first_byte_q, 1'b1);
        u_host.sel(1'b1);
        $display("partial done");
        end_of_test();
    end
endmodule // tb
bind asp_serial_pins asp_properties i_chk(.mclk, .rstn, .sclk, .cs_n, .cnv_pin, .conv_done, .dout_o, .dout_oe,
    .eoc_n_q, .cmd_valid_q, .cmd_byte_q, .first_byte_q, .convert_start_q, .cnv_is_start_q, .ref_minus_q,
    .clock_mode_select_q);
